// File: design/rpmf_pkg.sv
// Shared constants for the receive-port mode and forwarding block
package rpmf_pkg;
    localparam int NPORT = 4;
    localparam int NTX = 2;
    localparam int CLK_NS = 5;
    // Register offsets
    localparam logic [7:0] ADDR_FWD = 8'h20;
    localparam logic [7:0] ADDR_TXCFG = 8'h21;
    localparam logic [7:0] ADDR_STAT = 8'h4d;
    localparam logic [7:0] ADDR_RATE = 8'h58;
    localparam logic [7:0] ADDR_MODE = 8'h6d;
    localparam logic [7:0] ADDR_RAWHDR = 8'h70;
    localparam logic [7:0] ADDR_VCMAP = 8'h72;
    // Field positions
    localparam int FWD_DEST_LSB = 4;
    localparam int TXCFG_REPL_BIT = 4;
    // Input mode codes
    localparam logic [1:0] MODE_CSI = 2'h0;
    localparam logic [1:0] MODE_R12LF = 2'h1;
    localparam logic [1:0] MODE_R12HF = 2'h2;
    localparam logic [1:0] MODE_R10 = 2'h3;
    // Back channel rate codes
    localparam logic [2:0] RATE_2M5 = 3'h0;
    localparam logic [2:0] RATE_10M = 3'h2;
    localparam logic [2:0] RATE_50M = 3'h6;
    // Reset values
    localparam logic [7:0] FWD_RST = 8'h00;
    localparam logic [7:0] TXCFG_RST = 8'h0f;
    localparam logic [7:0] VCMAP_RST = 8'he4;
    localparam logic [7:0] RAWHDR_RST = 8'h2c;
    // Link frame layout
    localparam int CSI_FRAME_W = 40;
    localparam int RAW_FRAME_W = 28;
    localparam logic [1:0] FRAME_SYNC = 2'h2;
    // Back channel bit times
    localparam int BC_2M5_NS = 400;
    localparam int BC_10M_NS = 100;
    localparam int BC_50M_NS = 20;
    localparam logic [6:0] BC_2M5_CYC = 7'(BC_2M5_NS / CLK_NS);
    localparam logic [6:0] BC_10M_CYC = 7'(BC_10M_NS / CLK_NS);
    localparam logic [6:0] BC_50M_CYC = 7'(BC_50M_NS / CLK_NS);
    // Link clock ratios against the reference
    localparam int FWD_SYNC_MULT = 160;
    localparam int PCLK_SYNC_MULT = 4;
    localparam int BC_SYNC_MULT = 2;
    localparam int FWD_NSYNC_MULT = 80;
    localparam int FWD_MAX_MBPS = 4160;
    localparam int LANE_MAX_MBPS = 1664;
    // Pixel clock range check
    localparam int PCLK_WIN_NS = 1000;
    localparam logic [7:0] PCLK_WIN_CYC = 8'(PCLK_WIN_NS / CLK_NS);
    localparam int HF_MIN_KHZ = 37500;
    localparam int HF_MAX_KHZ = 100000;
    localparam int LF_MIN_KHZ = 25000;
    localparam int LF_MAX_KHZ = 50000;
    localparam int R10_MIN_KHZ = 50000;
    localparam int R10_MAX_KHZ = 100000;
    localparam logic [7:0] HF_LO = 8'(HF_MIN_KHZ * PCLK_WIN_NS / 1000000);
    localparam logic [7:0] HF_HI = 8'((HF_MAX_KHZ * PCLK_WIN_NS + 999999) / 1000000);
    localparam logic [7:0] LF_LO = 8'(LF_MIN_KHZ * PCLK_WIN_NS / 1000000);
    localparam logic [7:0] LF_HI = 8'((LF_MAX_KHZ * PCLK_WIN_NS + 999999) / 1000000);
    localparam logic [7:0] R10_LO = 8'(R10_MIN_KHZ * PCLK_WIN_NS / 1000000);
    localparam logic [7:0] R10_HI = 8'((R10_MAX_KHZ * PCLK_WIN_NS + 999999) / 1000000);
    // Least pixel clocks between sync changes in ten-bit raw mode
    localparam logic [3:0] SYNC_MIN_PCLK = 4'ha;
endpackage

// File: design/rpmf_top.sv
// Receive-port input mode selection and stream forwarding to two CSI-2 ports
`timescale 1ns/1ps
module rpmf_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Register access from the control channel, port page select
    input wire logic [1:0] reg_port_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    output logic [7:0] reg_rdata_o,
    // Mode strap ratio index from the strap comparator
    input wire logic [2:0] strap_idx_i,
    // Receive link pixel clocks and recovered frames
    input wire logic [rpmf_pkg::NPORT-1:0] link_pclk_i,
    input wire logic [rpmf_pkg::NPORT-1:0][39:0] link_frame_i,
    // Back channel bit pacing
    output logic [rpmf_pkg::NPORT-1:0] bc_tick_o,
    // CSI-2 transmit ports
    output logic [rpmf_pkg::NTX-1:0] tx_valid_o,
    output logic [rpmf_pkg::NTX-1:0][1:0] tx_vc_o,
    output logic [rpmf_pkg::NTX-1:0][5:0] tx_dt_o,
    output logic [rpmf_pkg::NTX-1:0][15:0] tx_data_o,
    output logic [rpmf_pkg::NTX-1:0][1:0] tx_lanes_o
);
    import rpmf_pkg::*;

    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // Strap is sampled through two flops, then loaded once after reset
    logic [2:0] strap_s1_ff;
    logic [2:0] strap_s2_ff;
    logic [1:0] strap_wait_ff;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            strap_s1_ff <= 3'h0;
            strap_s2_ff <= 3'h0;
            strap_wait_ff <= 2'h0;
        end else begin
            strap_s1_ff <= strap_idx_i;
            strap_s2_ff <= strap_s1_ff;
            if (strap_wait_ff != 2'h3) strap_wait_ff <= strap_wait_ff + 2'h1;
        end
    end
    wire strap_load = (strap_wait_ff == 2'h2);
    // four strap modes
    // Ratio indices repeat the four modes in both halves of the scale
    wire [1:0] strap_mode = strap_s2_ff[1:0];

    // Register write decode
    wire wr_fwd = reg_wr_i && (reg_addr_i == ADDR_FWD);
    wire wr_txcfg = reg_wr_i && (reg_addr_i == ADDR_TXCFG);
    wire wr_stat = reg_wr_i && (reg_addr_i == ADDR_STAT);
    wire wr_rate = reg_wr_i && (reg_addr_i == ADDR_RATE);
    wire wr_mode = reg_wr_i && (reg_addr_i == ADDR_MODE);
    wire wr_rawhdr = reg_wr_i && (reg_addr_i == ADDR_RAWHDR);
    wire wr_vcmap = reg_wr_i && (reg_addr_i == ADDR_VCMAP);

    // Shared forwarding and transmit setup
    logic [7:0] fwd_ff;
    logic [7:0] txcfg_ff;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            fwd_ff <= FWD_RST;
            txcfg_ff <= TXCFG_RST;
        end else begin
            if (wr_fwd) fwd_ff <= reg_wdata_i;
            if (wr_txcfg) txcfg_ff <= reg_wdata_i;
        end
    end
    // replica mode steers everything to port 0 and mirrors it
    wire repl = txcfg_ff[TXCFG_REPL_BIT];

    // Pixel clock measurement window, shared by all ports
    logic [7:0] win_cnt_ff;
    always_ff @(posedge clk_i) begin
        if (reset_i || win_cnt_ff == PCLK_WIN_CYC - 8'h1) win_cnt_ff <= 8'h0;
        else win_cnt_ff <= win_cnt_ff + 8'h1;
    end
    wire win_end = (win_cnt_ff == PCLK_WIN_CYC - 8'h1);

    // Per-port state
    logic [NPORT-1:0][1:0] mode_ff;
    logic [NPORT-1:0][2:0] rate_ff;
    logic [NPORT-1:0][7:0] rawhdr_ff;
    logic [NPORT-1:0][7:0] vcmap_ff;
    logic [NPORT-1:0][3:0] stat_ff;
    logic [NPORT-1:0] pend_v_ff;
    logic [NPORT-1:0][1:0] pend_vc_ff;
    logic [NPORT-1:0][5:0] pend_dt_ff;
    logic [NPORT-1:0][15:0] pend_data_ff;
    logic [NPORT-1:0] frame_ok;
    logic [NPORT-1:0] gnt_p;
    logic [NPORT-1:0] mode_set;

    for (genvar p = 0; p < NPORT; p++) begin : g_port
        wire sel = (reg_port_i == 2'(p));
        // strap value lands in the mode field, later writes override it
        assign mode_set[p] = strap_load || (wr_mode && sel);
        wire [1:0] nxt_mode = strap_load ? strap_mode : reg_wdata_i[1:0];
        wire is_csi = (mode_ff[p] == MODE_CSI);
        wire [2:0] dflt_rate = (nxt_mode == MODE_CSI) ? RATE_50M : RATE_2M5;

        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                mode_ff[p] <= MODE_CSI;
                rate_ff[p] <= RATE_50M;
                rawhdr_ff[p] <= RAWHDR_RST;
                vcmap_ff[p] <= VCMAP_RST;
            end else begin
                if (mode_set[p]) mode_ff[p] <= nxt_mode;
                if (mode_set[p]) rate_ff[p] <= dflt_rate;
                else if (wr_rate && sel) rate_ff[p] <= reg_wdata_i[2:0];
                if (wr_rawhdr && sel) rawhdr_ff[p] <= reg_wdata_i;
                if (wr_vcmap && sel) vcmap_ff[p] <= reg_wdata_i;
            end
        end

        // Link pins pass two flops, a third finds the pixel clock edge
        logic [2:0] pclk_sh_ff;
        logic [39:0] frm_s1_ff;
        logic [39:0] frm_s2_ff;
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                pclk_sh_ff <= 3'h0;
                frm_s1_ff <= '0;
                frm_s2_ff <= '0;
            end else begin
                pclk_sh_ff <= {pclk_sh_ff[1:0], link_pclk_i[p]};
                frm_s1_ff <= link_frame_i[p];
                frm_s2_ff <= frm_s1_ff;
            end
        end
        wire pedge = pclk_sh_ff[1] & ~pclk_sh_ff[2];

        // 40-bit CSI-2 frame: sync, VC, DT, control byte, payload, parity
        // 28-bit raw frame: sync, HS/VS, pixel, parity
        wire [39:0] frm = is_csi ? frm_s2_ff : {12'h0, frm_s2_ff[RAW_FRAME_W-1:0]};
        wire [1:0] fsync = is_csi ? frm[CSI_FRAME_W-1 -: 2] : frm[RAW_FRAME_W-1 -: 2];
        assign frame_ok[p] = pedge && (fsync == FRAME_SYNC) && !(^frm);
        wire frame_bad = pedge && !((fsync == FRAME_SYNC) && !(^frm));

        // incoming channel number remapped through a per-port table
        wire [1:0] csi_vc = vcmap_ff[p][2*frm[37:36] +: 2];
        // raw header fields come from the per-port register
        wire [1:0] nxt_vc = is_csi ? csi_vc : rawhdr_ff[p][7:6];
        wire [5:0] nxt_dt = is_csi ? frm[35:30] : rawhdr_ff[p][5:0];
        wire [15:0] raw_px = (mode_ff[p] == MODE_R10) ? {6'h0, frm[9:0]} : {4'h0, frm[11:0]};
        wire [15:0] nxt_data = is_csi ? frm[21:6] : raw_px;

        // One-entry holding stage; a frame that finds it full and not granted is dropped
        wire fwd_en = fwd_ff[p];
        wire take = frame_ok[p] && fwd_en && (!pend_v_ff[p] || gnt_p[p]);
        wire overrun = frame_ok[p] && fwd_en && pend_v_ff[p] && !gnt_p[p];
        // frames are held only when the port is enabled
        always_ff @(posedge clk_i) begin
            if (reset_i) pend_v_ff[p] <= 1'b0;
            else if (take) pend_v_ff[p] <= 1'b1;
            else if (gnt_p[p]) pend_v_ff[p] <= 1'b0;
        end
        always_ff @(posedge clk_i) begin
            if (take) begin
                pend_vc_ff[p] <= nxt_vc;
                pend_dt_ff[p] <= nxt_dt;
                pend_data_ff[p] <= nxt_data;
            end
        end

        // ten-bit raw sync spacing watched, violations flagged
        logic [1:0] hv_ff;
        logic [3:0] hv_gap_ff;
        wire hv_chg = frame_ok[p] && !is_csi && (frm[13:12] != hv_ff);
        wire hv_err = hv_chg && (mode_ff[p] == MODE_R10) && (hv_gap_ff < SYNC_MIN_PCLK);
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                hv_ff <= 2'h0;
                hv_gap_ff <= SYNC_MIN_PCLK;
            end else if (frame_ok[p] && !is_csi) begin
                hv_ff <= frm[13:12];
                if (hv_chg) hv_gap_ff <= 4'h1;
                else if (hv_gap_ff != SYNC_MIN_PCLK) hv_gap_ff <= hv_gap_ff + 4'h1;
            end
        end

        // pixel clock range checked per raw mode
        logic [7:0] edg_ff;
        logic [7:0] lo;
        logic [7:0] hi;
        always_comb begin
            case (mode_ff[p])
                MODE_R12HF: begin lo = HF_LO; hi = HF_HI; end
                MODE_R12LF: begin lo = LF_LO; hi = LF_HI; end
                MODE_R10: begin lo = R10_LO; hi = R10_HI; end
                default: begin lo = 8'h0; hi = 8'hff; end
            endcase
        end
        wire in_range = (edg_ff >= lo) && (edg_ff <= hi);
        always_ff @(posedge clk_i) begin
            if (reset_i || win_end) edg_ff <= 8'h0;
            else if (pedge && edg_ff != 8'hff) edg_ff <= edg_ff + 8'h1;
        end

        // Status: [0] clock in range, sticky [1] sync, [2] overrun, [3] frame
        // An event in the cycle of its write-one clear still sets the bit
        wire [3:1] clr = (wr_stat && sel) ? reg_wdata_i[3:1] : 3'h0;
        wire [3:1] evt = {frame_bad, overrun, hv_err};
        always_ff @(posedge clk_i) begin
            if (reset_i) stat_ff[p] <= 4'h0;
            else begin
                if (win_end) stat_ff[p][0] <= in_range;
                stat_ff[p][3:1] <= evt | (stat_ff[p][3:1] & ~clr);
            end
        end

        // 50 Mbps is twice the 25 MHz reference
        // code 010 paces the 10 Mbps back channel
        // non-synchronous serializers need the slower back channel
        wire [6:0] bc_per = (rate_ff[p] == RATE_50M) ? BC_50M_CYC :
                            (rate_ff[p] == RATE_10M) ? BC_10M_CYC : BC_2M5_CYC;
        logic [6:0] bc_cnt_ff;
        wire bc_wrap = (bc_cnt_ff >= bc_per - 7'h1);
        always_ff @(posedge clk_i) begin
            if (reset_i || bc_wrap) bc_cnt_ff <= 7'h0;
            else bc_cnt_ff <= bc_cnt_ff + 7'h1;
        end
        always_ff @(posedge clk_i) begin
            if (reset_i) bc_tick_o[p] <= 1'b0;
            else bc_tick_o[p] <= bc_wrap;
        end
    end

    // each port's destination is its bit in the forwarding register
    logic [NTX-1:0][NPORT-1:0] req;
    logic [NTX-1:0] gnt_any;
    logic [NTX-1:0][1:0] gnt_idx;
    logic [NTX-1:0][1:0] rr_ff;
    always_comb begin
        for (int t = 0; t < NTX; t++) begin
            gnt_any[t] = 1'b0;
            gnt_idx[t] = 2'h0;
            for (int p = 0; p < NPORT; p++) begin
                req[t][p] = pend_v_ff[p] &&
                    ((repl ? 1'b0 : fwd_ff[FWD_DEST_LSB + p]) == t[0]);
            end
            // Round robin keeps one busy sensor from starving the rest
            for (int k = 0; k < NPORT; k++) begin
                if (!gnt_any[t] && req[t][rr_ff[t] + 2'(k)]) begin
                    gnt_any[t] = 1'b1;
                    gnt_idx[t] = rr_ff[t] + 2'(k);
                end
            end
        end
    end
    for (genvar p = 0; p < NPORT; p++) begin : g_gnt
        assign gnt_p[p] = (gnt_any[0] && gnt_idx[0] == 2'(p)) ||
                          (gnt_any[1] && gnt_idx[1] == 2'(p));
    end

    // each word leaves tagged with its virtual channel number
    // output pacing never stalls the link side
    for (genvar t = 0; t < NTX; t++) begin : g_tx
        wire src_any = (repl && t == 1) ? gnt_any[0] : gnt_any[t];
        wire [1:0] src = (repl && t == 1) ? gnt_idx[0] : gnt_idx[t];
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                tx_valid_o[t] <= 1'b0;
                tx_vc_o[t] <= 2'h0;
                tx_dt_o[t] <= 6'h0;
                tx_data_o[t] <= 16'h0;
                rr_ff[t] <= 2'h0;
                tx_lanes_o[t] <= 2'h0;
            end else begin
                tx_valid_o[t] <= src_any;
                tx_vc_o[t] <= src_any ? pend_vc_ff[src] : 2'h0; // Unloaded stage stays hidden
                tx_dt_o[t] <= src_any ? pend_dt_ff[src] : 6'h0;
                tx_data_o[t] <= src_any ? pend_data_ff[src] : 16'h0;
                if (gnt_any[t]) rr_ff[t] <= gnt_idx[t] + 2'h1;
                // lane count minus one per output
                tx_lanes_o[t] <= txcfg_ff[2*t +: 2];
            end
        end
    end

    // Register read mux
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr_i)
            ADDR_FWD: rd_mux = fwd_ff;
            ADDR_TXCFG: rd_mux = txcfg_ff;
            ADDR_STAT: rd_mux = {4'h0, stat_ff[reg_port_i]};
            ADDR_RATE: rd_mux = {5'h0, rate_ff[reg_port_i]};
            ADDR_MODE: rd_mux = {6'h0, mode_ff[reg_port_i]};
            ADDR_RAWHDR: rd_mux = rawhdr_ff[reg_port_i];
            ADDR_VCMAP: rd_mux = vcmap_ff[reg_port_i];
            default: rd_mux = 8'h0;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) reg_rdata_o <= 8'h0;
        else reg_rdata_o <= rd_mux;
    end

    // Checks on port 0 and both transmit ports
    a_strap_mode: assert property (strap_load |=> mode_ff[0] == $past(strap_s2_ff[1:0]))
        else $error("strap mode not loaded");
    a_mode_write: assert property ((wr_mode && reg_port_i == 2'h0 && !strap_load)
        |=> mode_ff[0] == $past(reg_wdata_i[1:0]))
        else $error("mode write lost");
    a_csi_rate: assert property ((mode_set[0] && !strap_load &&
        reg_wdata_i[1:0] == MODE_CSI) |=> rate_ff[0] == RATE_50M)
        else $error("csi back channel default wrong");
    a_raw_rate: assert property ((mode_set[0] && !strap_load &&
        reg_wdata_i[1:0] != MODE_CSI) |=> rate_ff[0] == RATE_2M5)
        else $error("raw back channel default wrong");
    a_fwd_gated: assert property ((!fwd_ff[0] && !pend_v_ff[0]) |=> !pend_v_ff[0])
        else $error("disabled port forwarded");
    a_vc_remap: assert property ((frame_ok[0] && fwd_ff[0] && !pend_v_ff[0] &&
        mode_ff[0] == MODE_CSI) |=> pend_vc_ff[0] == $past(g_port[0].csi_vc))
        else $error("channel remap wrong");
    a_grant_out: assert property (gnt_any[0] |=> tx_valid_o[0] &&
        tx_data_o[0] == $past(pend_data_ff[gnt_idx[0]]))
        else $error("granted word not sent");
    a_replica: assert property (($past(repl) && tx_valid_o[0]) |-> tx_valid_o[1] &&
        tx_data_o[1] == tx_data_o[0] && tx_vc_o[1] == tx_vc_o[0])
        else $error("replica differs");
    a_bc_pace: assert property ((bc_tick_o[0] && rate_ff[0] == RATE_50M)
        ##1 (rate_ff[0] == RATE_50M)[*3] |=> bc_tick_o[0])
        else $error("back channel pacing wrong");
    c_strap: cover property (strap_load ##1 mode_ff[0] == MODE_R12HF);
    c_replica: cover property (repl && tx_valid_o[1]);
    c_raw_fwd: cover property (frame_ok[0] && mode_ff[0] != MODE_CSI && fwd_ff[0]);
    c_both_tx: cover property (tx_valid_o[0] && tx_valid_o[1] && !repl);
endmodule

// File: sim/rpmf_ser_model.sv
// Behavioural serializer model driving the four receive links
`timescale 1ns/1ps
module rpmf_ser_model (
    // Link pixel clocks and frames toward the hub
    output logic [3:0] pclk_o,
    output logic [3:0][39:0] frame_o
);
    // Pixel clocks stand still low between frames
    initial begin
        pclk_o = '0;
        frame_o = '0;
    end

    // One 64 ns pixel clock per frame; bad flips parity so the hub must refuse it
    task automatic send(input int p, input logic csi, input logic [39:0] b, input logic bad);
        logic [39:0] f;
        f = b;
        if (csi) begin
            f[39:38] = 2'b10;
            f[0] = ^f[39:1] ^ bad;
        end else begin
            f[39:26] = 14'h0002;
            f[14] = ^f[27:15] ^ ^f[13:0] ^ bad;
        end
        frame_o[p] = f;
        #16;
        pclk_o[p] = 1'b1;
        #32;
        pclk_o[p] = 1'b0;
        #16;
        // Hold time is over, so the line stops showing the old frame
        frame_o[p] = ~f;
    endtask
endmodule

// File: sim/testbench.sv
// Self-checking bench for receive-port mode selection and forwarding
`timescale 1ns/1ps
module testbench;
    import rpmf_pkg::*;
    localparam logic [39:0] CSI_BODY = {4'h1, 6'h2b, 8'h5a, 16'hbeef, 6'h00};
    logic clk_i;
    logic reset_i;
    logic [1:0] reg_port_i;
    logic [7:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic reg_wr_i;
    logic [7:0] reg_rdata_o;
    logic [2:0] strap_idx_i;
    logic [NPORT-1:0] link_pclk_i;
    logic [NPORT-1:0][39:0] link_frame_i;
    logic [NPORT-1:0] bc_tick_o;
    logic [NTX-1:0] tx_valid_o;
    logic [NTX-1:0][1:0] tx_vc_o;
    logic [NTX-1:0][5:0] tx_dt_o;
    logic [NTX-1:0][15:0] tx_data_o;
    logic [NTX-1:0][1:0] tx_lanes_o;
    int mismatches = 0;
    int n_tests = 0;
    int vcnt [NTX] = '{default: 0};
    logic [1:0] lvc [NTX];
    logic [5:0] ldt [NTX];
    logic [15:0] ldat [NTX];

    rpmf_top dut_u (.clk_i(clk_i), .reset_i(reset_i), .reg_port_i(reg_port_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rdata_o(reg_rdata_o), .strap_idx_i(strap_idx_i), .link_pclk_i(link_pclk_i),
        .link_frame_i(link_frame_i), .bc_tick_o(bc_tick_o), .tx_valid_o(tx_valid_o),
        .tx_vc_o(tx_vc_o), .tx_dt_o(tx_dt_o), .tx_data_o(tx_data_o), .tx_lanes_o(tx_lanes_o));
    rpmf_ser_model ser_u (.pclk_o(link_pclk_i), .frame_o(link_frame_i));

    // Free-running system clock
    initial begin
        clk_i = 1'b0;
        forever #(CLK_NS / 2.0) clk_i = ~clk_i;
    end

    // Keep the last word on each transmit port, sampled once the edge has settled
    always begin
        @(posedge clk_i);
        #1;
        for (int k = 0; k < NTX; k++) begin
            if (tx_valid_o[k] === 1'b1) begin
                vcnt[k]++;
                lvc[k] = tx_vc_o[k];
                ldt[k] = tx_dt_o[k];
                ldat[k] = tx_data_o[k];
            end
        end
    end

    task close_out();
        if (mismatches == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task check(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Write strobe is a one-cycle pulse launched at the falling edge
    task wr(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_port_i = p;
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask

    // Read data follows the address one edge later
    task rd(input logic [1:0] p, input logic [7:0] a, input logic [7:0] e,
            input logic [7:0] m = 8'hff);
        @(negedge clk_i);
        reg_port_i = p;
        reg_addr_i = a;
        @(posedge clk_i);
        @(posedge clk_i);
        #1;
        check("register read", {8'h00, e & m}, {8'h00, reg_rdata_o & m});
    endtask

    // Third gap is taken so a rate change in flight cannot skew it
    task gap(input int p, input logic [6:0] e);
        int n;
        n = 0;
        for (int i = 0; i < 3; i++) begin
            n = 0;
            do begin
                @(posedge clk_i);
                #1;
                n++;
            end while (bc_tick_o[p] !== 1'b1 && n < 200);
        end
        check("back channel tick gap", 16'(e), 16'(n));
    endtask

    task automatic xfer(input int p, input logic csi, input logic [39:0] b, input logic bad,
                        input logic [1:0] en, input logic [1:0] evc, input logic [5:0] edt,
                        input logic [15:0] ed);
        int c [NTX];
        c = vcnt;
        ser_u.send(p, csi, b, bad);
        repeat (20) @(negedge clk_i);
        for (int k = 0; k < NTX; k++) begin
            check("tx word count", 16'(en[k]), 16'(vcnt[k] - c[k]));
            if (en[k]) begin
                check("tx channel", 16'(evc), 16'(lvc[k]));
                check("tx data type", 16'(edt), 16'(ldt[k]));
                check("tx data", ed, ldat[k]);
            end
        end
    endtask

    // Bounded run time: the sequence needs under a thousand cycles
    initial begin
        #100000;
        mismatches++;
        close_out();
    end

    // Main sequence
    initial begin
        reset_i = 1'b1;
        reg_port_i = 2'h0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        strap_idx_i = 3'h6;
        repeat (12) @(negedge clk_i);
        reset_i = 1'b0;
        repeat (4) @(negedge clk_i);
        for (int p = 0; p < NPORT; p++) begin
            rd(2'(p), ADDR_MODE, {6'h00, MODE_R12HF});
            rd(2'(p), ADDR_RATE, {5'h00, RATE_2M5});
        end
        rd(0, ADDR_FWD, FWD_RST);
        rd(0, ADDR_TXCFG, TXCFG_RST);
        rd(0, ADDR_VCMAP, VCMAP_RST);
        rd(0, ADDR_RAWHDR, RAWHDR_RST);
        rd(0, 8'h33, 8'h00);
        check("lane count", 16'h000f, 16'(tx_lanes_o));
        for (int m = 0; m < 4; m++) begin
            wr(1, ADDR_MODE, 8'(m));
            rd(1, ADDR_MODE, 8'(m));
            rd(1, ADDR_RATE, (m == 0) ? {5'h00, RATE_50M} : {5'h00, RATE_2M5});
        end
        rd(2, ADDR_MODE, {6'h00, MODE_R12HF});
        wr(1, ADDR_RATE, {5'h00, RATE_10M});
        rd(1, ADDR_RATE, {5'h00, RATE_10M});
        gap(1, BC_10M_CYC);
        wr(1, ADDR_RATE, {5'h00, RATE_50M});
        gap(1, BC_50M_CYC);
        wr(1, ADDR_RATE, {5'h00, RATE_2M5});
        gap(1, BC_2M5_CYC);
        wr(0, ADDR_MODE, {6'h00, MODE_CSI});
        xfer(0, 1, CSI_BODY, 0, 2'b00, 2'h0, 6'h00, 16'h0000);
        wr(0, ADDR_VCMAP, 8'hec);
        wr(0, ADDR_FWD, 8'h01);
        xfer(0, 1, CSI_BODY, 0, 2'b01, 2'h3, 6'h2b, 16'hbeef);
        wr(0, ADDR_FWD, 8'h11);
        xfer(0, 1, CSI_BODY, 0, 2'b10, 2'h3, 6'h2b, 16'hbeef);
        xfer(0, 1, CSI_BODY, 1, 2'b00, 2'h0, 6'h00, 16'h0000);
        rd(0, ADDR_STAT, 8'h08, 8'h08);
        wr(0, ADDR_STAT, 8'h0e);
        rd(0, ADDR_STAT, 8'h00, 8'h08);
        wr(0, ADDR_TXCFG, 8'h15);
        xfer(0, 1, CSI_BODY, 0, 2'b11, 2'h3, 6'h2b, 16'hbeef);
        check("lane count", 16'h0005, 16'(tx_lanes_o));
        wr(0, ADDR_TXCFG, TXCFG_RST);
        wr(0, ADDR_FWD, 8'h01);
        wr(0, ADDR_MODE, {6'h00, MODE_R12LF});
        wr(0, ADDR_RAWHDR, 8'h9e);
        xfer(0, 0, 40'ha5c, 0, 2'b01, 2'h2, 6'h1e, 16'h0a5c);
        wr(0, ADDR_MODE, {6'h00, MODE_R12HF});
        xfer(0, 0, 40'h5a3, 0, 2'b01, 2'h2, 6'h1e, 16'h05a3);
        wr(0, ADDR_MODE, {6'h00, MODE_R10});
        xfer(0, 0, 40'hec3, 0, 2'b01, 2'h2, 6'h1e, 16'h02c3);
        xfer(0, 0, 40'h12c3, 0, 2'b01, 2'h2, 6'h1e, 16'h02c3);
        xfer(0, 0, 40'hec3, 0, 2'b01, 2'h2, 6'h1e, 16'h02c3);
        rd(0, ADDR_STAT, 8'h02, 8'h02);
        close_out();
    end
endmodule
